// ===== wkl_wake_input.sv
// Wake input logic: filtered level-change detection, signalling, status.
// Assumes mode and control bits come from the chip's mode and SPI logic.
//
// What this block does
// [R1] Both pin edges count as wake events
// [R2] Normal/Stop: event raises interrupt, no mode change
// [R3] Sleep/Fail-Safe: event wakes the device
// [R4] Enable bit gates wake from Sleep
// [R5] Interrupt only after wake filter time
// [R6] Fail-Safe: any edge requests Restart, enable ignored
// [R7] Event recorded in readable wake flag
// [R8] Normal/Stop: live pin level readable
// [R9] Config bit makes pin converter selector
// [R10] Stop: low selects PFM, high PWM
// [R11] Selector uses pin level without filter
// [R12] Selector use still allows Sleep wake
// [R13] Two-bit current source incl. automatic switching
// [R14] Filter counter restarts when level reverts
module wkl_wake_input
    import wkl_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic clk_en_i,
    input wire logic wake_pin_i,
    input wire logic [1:0] mode_i,
    input wire logic wake_pin_enable_i,
    input wire logic converter_select_by_pin_i,
    input wire logic [1:0] pin_current_source_control_i,
    input wire logic flag_clear_i,
    output logic wake_pin_event_flag_o,
    output logic pin_level_status_o,
    output logic int_req_o,
    output logic wake_to_normal_o,
    output logic wake_to_restart_o,
    output logic pwm_select_o,
    output logic pull_up_en_o,
    output logic pull_down_en_o
);

    logic [1:0] rst_sync_ff;
    logic rst_n;
    logic level;
    logic filt;
    logic change;
    wkl_mode_t mode;
    logic flag_ff;
    logic lvl_stat_ff;
    logic int_ff;
    logic wake_norm_ff;
    logic wake_rst_ff;
    logic pwm_ff;
    logic pu_ff;
    logic pd_ff;
    logic selector_active;
    logic nxt_int;
    logic nxt_wake_norm;
    logic nxt_wake_rst;

    // Normal or Stop decoding, used in several places
    function automatic logic is_awake(input wkl_mode_t m);
        is_awake = (m == WKL_MODE_NORMAL) || (m == WKL_MODE_STOP);
    endfunction

    // ************************************************
    // Reset release
    // ************************************************
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_sync_ff <= WKL_SYNC_RST;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    assign mode = wkl_mode_t'(mode_i);

    // ************************************************
    // Pin conditioning
    // ************************************************
    wkl_filter u_filter (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .en_i(clk_en_i),
        .pin_i(wake_pin_i),
        .level_o(level),
        .filt_o(filt),
        .change_o(change)
    );

    // [R9] selector use in Stop mode
    assign selector_active = converter_select_by_pin_i && (mode == WKL_MODE_STOP);

    // Signalling decision per mode
    always_comb begin
        nxt_int = 1'b0;
        nxt_wake_norm = 1'b0;
        nxt_wake_rst = 1'b0;
        case (mode)
            WKL_MODE_NORMAL: begin
                // [R2] interrupt after filter
                nxt_int = change && wake_pin_enable_i;
            end
            WKL_MODE_STOP: begin
                // [R5] filtered change, not in selector use
                nxt_int = change && wake_pin_enable_i && !selector_active;
            end
            WKL_MODE_SLEEP: begin
                // [R4] [R12] enable gates Sleep wake
                nxt_wake_norm = change && wake_pin_enable_i;
            end
            WKL_MODE_FAILSAFE: begin
                // [R6] always a wake source
                nxt_wake_rst = change;
            end
            default: begin
                nxt_int = 1'b0;
            end
        endcase
    end

    // [R3] signalling pulses toward mode and interrupt logic
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            int_ff <= 1'b0;
            wake_norm_ff <= 1'b0;
            wake_rst_ff <= 1'b0;
        end else if (clk_en_i) begin
            int_ff <= nxt_int;
            wake_norm_ff <= nxt_wake_norm;
            wake_rst_ff <= nxt_wake_rst;
        end
    end

    // [R7] sticky flag, set wins over clear
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            flag_ff <= 1'b0;
        end else if (clk_en_i) begin
            if (nxt_int || nxt_wake_norm || nxt_wake_rst) begin
                flag_ff <= 1'b1;
            end else if (flag_clear_i) begin
                flag_ff <= 1'b0;
            end
        end
    end

    // [R8] live level in Normal/Stop
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            lvl_stat_ff <= WKL_LVL_RST;
        end else if (clk_en_i && is_awake(mode)) begin
            lvl_stat_ff <= level;
        end
    end

    // [R10] [R11] unfiltered converter selection
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pwm_ff <= 1'b0;
        end else if (clk_en_i) begin
            pwm_ff <= selector_active && level;
        end
    end

    // [R13] current source control
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pu_ff <= 1'b0;
            pd_ff <= 1'b0;
        end else if (clk_en_i) begin
            case (pin_current_source_control_i)
                WKL_PUPD_NONE: begin
                    pu_ff <= 1'b0;
                    pd_ff <= 1'b0;
                end
                WKL_PUPD_DOWN: begin
                    pu_ff <= 1'b0;
                    pd_ff <= 1'b1;
                end
                WKL_PUPD_UP: begin
                    pu_ff <= 1'b1;
                    pd_ff <= 1'b0;
                end
                default: begin
                    pu_ff <= level;
                    pd_ff <= !level;
                end
            endcase
        end
    end

    assign wake_pin_event_flag_o = flag_ff;
    assign pin_level_status_o = lvl_stat_ff;
    assign int_req_o = int_ff;
    assign wake_to_normal_o = wake_norm_ff;
    assign wake_to_restart_o = wake_rst_ff;
    assign pwm_select_o = pwm_ff;
    assign pull_up_en_o = pu_ff;
    assign pull_down_en_o = pd_ff;

    // ************************************************
    // Checks
    // ************************************************
    sequence s_change_in(wkl_mode_t m);
        clk_en_i && change && (mode == m);
    endsequence

    sequence s_pulse_out(logic sig);
        clk_en_i ##1 sig;
    endsequence

    // [R2] check
    property p_int_normal;
        @(posedge clk_i) disable iff (!rst_n)
        s_change_in(WKL_MODE_NORMAL) and (wake_pin_enable_i) |=> int_req_o && !wake_to_normal_o;
    endproperty
    a_int_normal: assert property (p_int_normal) else $error("missing interrupt in normal mode"); // [R2]

    // [R3] check
    property p_sleep_wake;
        @(posedge clk_i) disable iff (!rst_n)
        s_change_in(WKL_MODE_SLEEP) and (wake_pin_enable_i) |-> s_pulse_out(wake_to_normal_o);
    endproperty
    a_sleep_wake: assert property (p_sleep_wake) else $error("missing sleep wake"); // [R3]

    // [R4] check
    property p_enable_gate;
        @(posedge clk_i) disable iff (!rst_n)
        clk_en_i && !wake_pin_enable_i |=> !wake_to_normal_o && !int_req_o;
    endproperty
    a_enable_gate: assert property (p_enable_gate) else $error("event passed while disabled"); // [R4]

    // [R6] check
    property p_failsafe;
        @(posedge clk_i) disable iff (!rst_n)
        s_change_in(WKL_MODE_FAILSAFE) |-> s_pulse_out(wake_to_restart_o);
    endproperty
    a_failsafe: assert property (p_failsafe) else $error("missing restart request"); // [R6]

    // [R7] check
    property p_flag_set;
        @(posedge clk_i) disable iff (!rst_n)
        clk_en_i && (nxt_int || nxt_wake_norm || nxt_wake_rst) |=> wake_pin_event_flag_o;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("wake flag not set"); // [R7]

    // [R5] check
    property p_filter_hold;
        @(posedge clk_i) disable iff (!rst_n)
        $rose(int_req_o) |-> $past(change);
    endproperty
    a_filter_hold: assert property (p_filter_hold) else $error("interrupt without filtered change"); // [R5]

    // [R10] check
    property p_pwm_level;
        @(posedge clk_i) disable iff (!rst_n)
        clk_en_i && selector_active |=> pwm_select_o == $past(level);
    endproperty
    a_pwm_level: assert property (p_pwm_level) else $error("converter select wrong"); // [R10]

    // [R13] check
    property p_pupd_auto;
        @(posedge clk_i) disable iff (!rst_n)
        clk_en_i && (pin_current_source_control_i == WKL_PUPD_AUTO)
            |=> pull_up_en_o == $past(level) && pull_down_en_o != $past(level);
    endproperty
    a_pupd_auto: assert property (p_pupd_auto) else $error("automatic current source wrong"); // [R13]

    // [R8] check
    property p_level_stat;
        @(posedge clk_i) disable iff (!rst_n)
        clk_en_i && is_awake(mode) |=> pin_level_status_o == $past(level);
    endproperty
    a_level_stat: assert property (p_level_stat) else $error("level status stale"); // [R8]

endmodule

// ===== wkl_pkg.sv
// Shared constants and types of the wake input logic.
// Assumes a 100 MHz core clock from the internal oscillator.
package wkl_pkg;

    // Chip operating modes, as seen by the wake input
    typedef enum logic [1:0] {
        WKL_MODE_NORMAL = 2'h0,
        WKL_MODE_STOP = 2'h1,
        WKL_MODE_SLEEP = 2'h2,
        WKL_MODE_FAILSAFE = 2'h3
    } wkl_mode_t;

    // Current source settings
    localparam logic [1:0] WKL_PUPD_NONE = 2'h0;
    localparam logic [1:0] WKL_PUPD_DOWN = 2'h1;
    localparam logic [1:0] WKL_PUPD_UP = 2'h2;
    localparam logic [1:0] WKL_PUPD_AUTO = 2'h3;

    // Wake filter timing
    localparam int WKL_CLK_MHZ = 100;
    localparam int WKL_FILTER_TIME_US = 16;
    localparam int WKL_FILTER_CYC = WKL_FILTER_TIME_US * WKL_CLK_MHZ;
    localparam int WKL_CNT_W = 11;
    localparam logic [WKL_CNT_W-1:0] WKL_FILTER_LAST = WKL_CNT_W'(WKL_FILTER_CYC - 1);
    localparam logic [WKL_CNT_W-1:0] WKL_CNT_ZERO = 11'h000;

    // Reset values
    localparam logic WKL_LVL_RST = 1'b0;
    localparam logic [1:0] WKL_SYNC_RST = 2'h0;

endpackage

// ===== wkl_filter.sv
// Pin synchroniser and wake filter for the wake pin.
// Assumes a reset already synchronised to clk_i.
module wkl_filter
    import wkl_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic en_i,
    input wire logic pin_i,
    output logic level_o,
    output logic filt_o,
    output logic change_o
);

    logic sync1_ff;
    logic sync2_ff;
    logic sync3_ff;
    logic level_ff;
    logic filt_ff;
    logic change_ff;
    logic [WKL_CNT_W-1:0] cnt_ff;

    // ************************************************
    // Three-stage pin synchroniser
    // ************************************************
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_ff <= WKL_LVL_RST;
            sync2_ff <= WKL_LVL_RST;
            sync3_ff <= WKL_LVL_RST;
        end else if (en_i) begin
            sync1_ff <= pin_i;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    // Level accepted once last two stages agree
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            level_ff <= WKL_LVL_RST;
        end else if (en_i && (sync2_ff == sync3_ff)) begin
            level_ff <= sync3_ff;
        end
    end

    // [R14] filter counter, restarts on reversion
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_ff <= WKL_CNT_ZERO;
            filt_ff <= WKL_LVL_RST;
            change_ff <= 1'b0;
        end else if (en_i) begin
            change_ff <= 1'b0;
            if (level_ff == filt_ff) begin
                cnt_ff <= WKL_CNT_ZERO;
            end else if (cnt_ff == WKL_FILTER_LAST) begin
                cnt_ff <= WKL_CNT_ZERO;
                filt_ff <= level_ff;
                change_ff <= 1'b1; // [R1] either direction
            end else begin
                cnt_ff <= cnt_ff + 11'h001;
            end
        end
    end

    assign level_o = level_ff;
    assign filt_o = filt_ff;
    assign change_o = change_ff;

endmodule

// ===== wkl_pin_driver.sv
// Model of the external switch or sensor on the wake pin.
// Assumes the bench sets its commands at falling clock edges.
module wkl_pin_driver (
    input wire logic clk_i,
    input wire logic drive_en_i,
    input wire logic drive_lvl_i,
    input wire logic chatter_i,
    input wire logic pull_up_i,
    input wire logic pull_down_i,
    output logic pin_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****
    // Pin level
    // ****
    logic [6:0] wander_ff = 7'h00;

    // Bounce phase flips every 64 cycles, well inside the filter time
    always_ff @(posedge clk_i) begin
        wander_ff <= wander_ff + 7'h01;
    end

    always_comb begin
        if (chatter_i) begin
            pin_o = wander_ff[6]; // Contact bounce
        end else if (drive_en_i) begin
            pin_o = drive_lvl_i;
        end else if (pull_up_i && !pull_down_i) begin
            pin_o = 1'b1;
        end else if (pull_down_i && !pull_up_i) begin
            pin_o = 1'b0;
        end else begin
            pin_o = wander_ff[6];
        end
    end
endmodule

// ===== testbench.sv
// Self-checking bench of the wake input logic.
// Assumes a 100 MHz clock; the pin is driven by the switch model.
module testbench import wkl_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    // ****
    // Signals
    // ****
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [1:0] mode = 2'h0;
    logic en = 1'b0;
    logic sel = 1'b0;
    logic [1:0] pupd = 2'h0;
    logic clr = 1'b0;
    logic drv_en = 1'b1;
    logic drv_lvl = 1'b0;
    logic chat = 1'b0;
    logic clken = 1'b1;
    logic cnt_clr = 1'b0;
    logic pin, flag, lvl, irq, wn, rs, pwm, pu, pd;
    logic [1:0] cnt_i = 2'h0;
    logic [1:0] cnt_w = 2'h0;
    logic [1:0] cnt_r = 2'h0;
    int miscompares = 0;
    int n_compared = 0;
    int seed = 66335;
    logic [2:0] rnd;

    always #5 clk = ~clk;

    wkl_wake_input wkl_wake_input_inst (
        .clk_i(clk), .nrst_i(nrst), .clk_en_i(clken), .wake_pin_i(pin), .mode_i(mode),
        .wake_pin_enable_i(en), .converter_select_by_pin_i(sel),
        .pin_current_source_control_i(pupd), .flag_clear_i(clr),
        .wake_pin_event_flag_o(flag), .pin_level_status_o(lvl), .int_req_o(irq),
        .wake_to_normal_o(wn), .wake_to_restart_o(rs), .pwm_select_o(pwm),
        .pull_up_en_o(pu), .pull_down_en_o(pd)
    );

    wkl_pin_driver wkl_pin_driver_inst (
        .clk_i(clk), .drive_en_i(drv_en), .drive_lvl_i(drv_lvl), .chatter_i(chat),
        .pull_up_i(pu), .pull_down_i(pd), .pin_o(pin)
    );

    // Pulse counters
    always @(posedge clk) begin
        if (cnt_clr) begin
            {cnt_i, cnt_w, cnt_r} <= 6'h00;
        end else begin
            if (irq === 1'b1) cnt_i <= cnt_i + 2'h1;
            if (wn === 1'b1) cnt_w <= cnt_w + 2'h1;
            if (rs === 1'b1) cnt_r <= cnt_r + 2'h1;
        end
    end

    // ****
    // Helpers
    // ****
    task automatic check(input logic [5:0] seen, input logic [5:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Expected pulses {interrupt, wake, restart}
    function automatic logic [2:0] exp_evt(input logic [1:0] m, input logic e, input logic s);
        case (m)
            WKL_MODE_NORMAL: exp_evt = {e, 2'h0};
            WKL_MODE_STOP: exp_evt = {e & ~s, 2'h0};
            WKL_MODE_SLEEP: exp_evt = {1'b0, e, 1'b0};
            default: exp_evt = 3'h1;
        endcase
    endfunction

    function automatic logic [1:0] exp_pull(input logic [1:0] c, input logic l);
        case (c)
            WKL_PUPD_NONE: exp_pull = 2'h0;
            WKL_PUPD_DOWN: exp_pull = 2'h1;
            WKL_PUPD_UP: exp_pull = 2'h2;
            default: exp_pull = {l, ~l};
        endcase
    endfunction

    // One pin edge under the given mode and control bits
    task automatic evt(input logic [1:0] m, input logic e, input logic s);
        logic [2:0] x;
        x = exp_evt(m, e, s);
        mode = m;
        en = e;
        sel = s;
        clr = 1'b1;
        cnt_clr = 1'b1;
        @(negedge clk);
        clr = 1'b0;
        cnt_clr = 1'b0;
        @(negedge clk);
        check({5'h0, flag}, 6'h00);
        drv_lvl = ~drv_lvl;
        repeat (8) @(negedge clk);
        check({5'h0, pwm}, {5'h0, (m == WKL_MODE_STOP) & s & drv_lvl});
        repeat (1592) @(negedge clk);
        check({cnt_i, cnt_w, cnt_r}, 6'h00);
        repeat (100) @(negedge clk);
        check({cnt_i, cnt_w, cnt_r}, {1'b0, x[2], 1'b0, x[1], 1'b0, x[0]});
        check({5'h0, flag}, {5'h0, |x});
        if (m < 2'h2) check({5'h0, lvl}, {5'h0, drv_lvl});
    endtask

    // ****
    // Main sequence
    // ****
    initial begin
        repeat (6) @(negedge clk);
        check({irq, wn, rs, flag, pwm, pu}, 6'h00);
        nrst = 1'b1;
        repeat (4) @(negedge clk);
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 16; k++) begin
                evt(k[1:0], k[2], k[3]);
            end
            rnd = 3'($random(seed));
            evt(rnd[1:0], rnd[2], 1'b0);
        end
        $display("edge tests done");
        // Bounce shorter than the filter
        mode = WKL_MODE_NORMAL;
        en = 1'b1;
        cnt_clr = 1'b1;
        chat = 1'b1;
        @(negedge clk);
        cnt_clr = 1'b0;
        repeat (3400 + ($random(seed) & 511)) @(negedge clk);
        chat = 1'b0;
        repeat (1700) @(negedge clk);
        check({cnt_i, cnt_w, cnt_r}, 6'h00);
        $display("bounce test done");
        // Clock enable low freezes filter and status
        cnt_clr = 1'b1;
        clken = 1'b0;
        drv_lvl = ~drv_lvl;
        @(negedge clk);
        cnt_clr = 1'b0;
        repeat (1700) @(negedge clk);
        check({cnt_i, cnt_w, cnt_r}, 6'h00);
        check({5'h0, lvl}, {5'h0, ~drv_lvl});
        clken = 1'b1;
        repeat (1700) @(negedge clk);
        check({cnt_i, cnt_w, cnt_r}, 6'h10);
        check({4'h0, lvl, flag}, {4'h0, drv_lvl, 1'b1});
        $display("clock enable test done");
        for (int k = 0; k < 8; k++) begin
            pupd = k[1:0];
            drv_lvl = k[2];
            repeat (8) @(negedge clk);
            check({4'h0, pu, pd}, {4'h0, exp_pull(k[1:0], k[2])});
        end
        drv_en = 1'b0;
        pupd = WKL_PUPD_DOWN;
        repeat (8) @(negedge clk);
        check({5'h0, lvl}, 6'h00);
        $display("current source test done");
        stop_test();
    end

    // Watchdog
    initial begin
        repeat (90000) @(posedge clk);
        miscompares++;
        stop_test();
    end
endmodule
